// ---- src/kei_cfg.svh ----
`ifndef KEI_CFG_SVH
`define KEI_CFG_SVH

// ****************************************************************
// register map and reset values
// ****************************************************************
`define KEI_ENABLE_ADDR 16'hFF6E
`define KEI_ENABLE_RST 8'h00
`define KEI_RDATA_IDLE 8'h00
`define KEI_REG_WIDTH 8
`define KEI_ADDR_WIDTH 16
`define KEI_BITSEL_WIDTH 3

// ****************************************************************
// channel count and timing
// ****************************************************************
`define KEI_NUM_CH 8
`define KEI_PIN_TO_PULSE 3

`endif

// ---- src/kei_key_edge_interrupt.sv ----
`timescale 1ns/1ps
`include "kei_cfg.svh"

module kei_key_edge_interrupt #(
   parameter int NUM_CH = `KEI_NUM_CH
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // key pins from the port
   input wire logic [NUM_CH-1:0] key_input_pin,
   // cpu register access
   input wire kei_pkg::kei_cpu_req_t cpu_req,
   output logic [`KEI_REG_WIDTH-1:0] cpu_rdata,
   // interrupt flag controls
   input wire kei_pkg::kei_irq_ctl_t irq_ctl,
   // interrupt outputs
   output logic key_interrupt_request,
   output logic key_flag,
   output logic key_irq_pending,
   // port view of pins and enable state
   output logic [NUM_CH-1:0] port_pin_level,
   output logic [`KEI_REG_WIDTH-1:0] key_detect_enable
);

   import kei_pkg::*;

   // ****************************************************************
   // helpers
   // ****************************************************************

   // address decode, used by both write and read paths
   function automatic logic enable_hit(
      input logic [`KEI_ADDR_WIDTH-1:0] addr
   );
      enable_hit = (addr == `KEI_ENABLE_ADDR);
   endfunction

   // bits that exist in this channel count
   function automatic logic [`KEI_REG_WIDTH-1:0] impl_mask(
      input int n
   );
      logic [`KEI_REG_WIDTH-1:0] m;
      m = '0;
      for (int i = 0; i < `KEI_REG_WIDTH; i++) begin
         if (i < n) begin
            m[i] = 1'b1;
         end
      end
      impl_mask = m;
   endfunction

   localparam logic [`KEI_REG_WIDTH-1:0] IMPL = impl_mask(NUM_CH);

   // ****************************************************************
   // reset release
   // ****************************************************************
   logic rst_meta_reg;
   logic rst_n;

   // asynchronous assert, synchronous release
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // ****************************************************************
   // pin synchroniser
   // ****************************************************************
   logic [NUM_CH-1:0] pin_sync;

   kei_pin_sync #(
      .WIDTH(NUM_CH)
   ) u_sync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .pin_async(key_input_pin),
      .pin_sync(pin_sync)
   );

   // ****************************************************************
   // enable register
   // ****************************************************************
   logic [`KEI_REG_WIDTH-1:0] enable_reg;
   logic [`KEI_REG_WIDTH-1:0] enable_next;
   logic wr_hit;

   assign wr_hit = enable_hit(cpu_req.addr);

   // byte write replaces all, bit write only the selected bit
   always_comb begin
      enable_next = enable_reg;
      if (wr_hit && cpu_req.byte_wr) begin
         enable_next = cpu_req.wdata & IMPL;
      end else if (wr_hit && cpu_req.bit_wr) begin
         enable_next[cpu_req.bit_sel] = cpu_req.bit_val;
         enable_next = enable_next & IMPL;
      end
   end

   // cleared by every reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_reg <= `KEI_ENABLE_RST;
      end else begin
         enable_reg <= enable_next;
      end
   end

   // registered read data, zero for other addresses
   logic [`KEI_REG_WIDTH-1:0] rdata_reg;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= `KEI_RDATA_IDLE;
      end else if (cpu_req.rd && enable_hit(cpu_req.addr)) begin
         rdata_reg <= enable_reg;
      end else begin
         rdata_reg <= `KEI_RDATA_IDLE;
      end
   end

   // ****************************************************************
   // detection
   // ****************************************************************
   logic [NUM_CH-1:0] active;
   logic [NUM_CH-1:0] active_prev_reg;
   logic pulse_next;
   logic pulse_reg;

   // a pin counts while enabled and low
   assign active = enable_reg[NUM_CH-1:0] & ~pin_sync;
   // new activity: falling edge or enable of a low pin
   assign pulse_next = |(active & ~active_prev_reg);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         active_prev_reg <= '0;
         pulse_reg <= 1'b0;
      end else begin
         active_prev_reg <= active;
         pulse_reg <= pulse_next;
      end
   end

   // ****************************************************************
   // request flag and acknowledge gating
   // ****************************************************************
   logic flag_reg;
   logic pending_reg;

   // set wins over a clear in the same cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= pulse_reg | (flag_reg & ~irq_ctl.flag_clr);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pending_reg <= 1'b0;
      end else begin
         pending_reg <= flag_reg & ~irq_ctl.mask & irq_ctl.global_ie;
      end
   end

   // port view of the pins, independent of enables
   logic [NUM_CH-1:0] port_level_reg;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         port_level_reg <= {NUM_CH{1'b1}};
      end else begin
         port_level_reg <= pin_sync;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign cpu_rdata = rdata_reg;
   assign key_interrupt_request = pulse_reg;
   assign key_flag = flag_reg;
   assign key_irq_pending = pending_reg;
   assign port_pin_level = port_level_reg;
   assign key_detect_enable = enable_reg;

   // ****************************************************************
   // assertions
   // ****************************************************************
   a_fall_to_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (active_prev_reg == '0 && active != '0) |=> pulse_reg)
      else $error("enabled falling edge gave no pulse");

   a_disabled_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (enable_reg == '0) |=> !pulse_reg)
      else $error("pulse with no pin enabled");

   a_read_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cpu_req.rd && cpu_req.addr == `KEI_ENABLE_ADDR)
      |=> (rdata_reg == $past(enable_reg)))
      else $error("read data differs from enable register");

   a_reset_clear: assert property (@(posedge ref_clk)
      $rose(rst_n) |-> (enable_reg == `KEI_ENABLE_RST))
      else $error("enable register not clear after reset");

   a_bit_write_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_hit && cpu_req.bit_wr && !cpu_req.byte_wr)
      |=> ((enable_reg ^ $past(enable_reg))
           & ~(8'h01 << $past(cpu_req.bit_sel))) == '0)
      else $error("bit write changed other bits");

   a_byte_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_hit && cpu_req.byte_wr)
      |=> enable_reg == ($past(cpu_req.wdata) & IMPL))
      else $error("byte write not stored");

   a_enable_low_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (|(~enable_reg[NUM_CH-1:0] & enable_next[NUM_CH-1:0] & ~pin_sync)
       && $stable(pin_sync) && !pulse_next) |=> ##1 pulse_reg)
      else $error("enabling a low pin gave no pulse");

   a_pulse_single: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $stable(active) |=> !pulse_reg)
      else $error("pulse without new key activity");

   a_flag_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pulse_reg |=> flag_reg)
      else $error("flag lost a set");

   a_pending_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pending_reg |-> $past(flag_reg) && !$past(irq_ctl.mask)
      && $past(irq_ctl.global_ie))
      else $error("pending without unmasked flag");

   c_key_press: cover property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(pin_sync[0]) && enable_reg[0] ##1 pulse_reg);
   c_flag_ack: cover property (@(posedge ref_clk) disable iff (!rst_n)
      flag_reg ##1 pending_reg);
   c_set_clr_same: cover property (@(posedge ref_clk) disable iff (!rst_n)
      pulse_reg && irq_ctl.flag_clr);

endmodule

// ---- src/kei_pin_sync.sv ----
`timescale 1ns/1ps

// two-flop synchroniser for the key pins
module kei_pin_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // asynchronous pins in, synchronous levels out
   input wire logic [WIDTH-1:0] pin_async,
   output logic [WIDTH-1:0] pin_sync
);

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   // idle key lines are pulled up, so reset to high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_reg <= {WIDTH{1'b1}};
         stage2_reg <= {WIDTH{1'b1}};
      end else begin
         stage1_reg <= pin_async;
         stage2_reg <= stage1_reg;
      end
   end

   assign pin_sync = stage2_reg;

endmodule

// ---- src/kei_pkg.sv ----
`include "kei_cfg.svh"

package kei_pkg;

   // ****************************************************************
   // cpu memory manipulation request toward the enable register
   // ****************************************************************
   typedef struct packed {
      logic [`KEI_ADDR_WIDTH-1:0] addr;
      logic byte_wr;
      logic bit_wr;
      logic [`KEI_BITSEL_WIDTH-1:0] bit_sel;
      logic bit_val;
      logic rd;
      logic [`KEI_REG_WIDTH-1:0] wdata;
   } kei_cpu_req_t;

   // ****************************************************************
   // interrupt flag controls from the interrupt controller side
   // ****************************************************************
   typedef struct packed {
      logic flag_clr;
      logic mask;
      logic global_ie;
   } kei_irq_ctl_t;

endpackage

// ---- tb/kei_key_model.sv ----
`timescale 1ns/1ps

// key switches on the port pins, with pull-ups on every line
module kei_key_model #(
   parameter int DLY = 37
) (
   // switch closures from the bench
   input wire logic [7:0] press,
   // pin levels toward the block
   output logic [7:0] pin
);
   // released pins are pulled high, settling off the clock edge
   initial pin = 8'hFF;
   always @(press) pin <= #DLY ~press;
endmodule

// ---- tb/key_edge_interrupt_test.sv ----
`timescale 1ns/1ps

module key_edge_interrupt_test;
   import kei_pkg::*;
   logic ref_clk;
   logic resetn;
   logic [7:0] press;
   logic [7:0] pins;
   logic [7:0] rdata;
   logic [7:0] en;
   logic [7:0] lvl;
   logic [7:0] d;
   logic req_p;
   logic flag;
   logic pend;
   kei_cpu_req_t req;
   kei_irq_ctl_t ctl;
   int n_errors = 0;
   int n_tests = 0;
   int npulse = 0;
   logic [7:0] en4;
   logic flag4;
   logic narrow = 1'b0;
   kei_cpu_req_t req4;

   kei_key_model keys (.press(press), .pin(pins));
   kei_key_edge_interrupt uut (.ref_clk(ref_clk), .resetn(resetn),
      .key_input_pin(pins), .cpu_req(req), .cpu_rdata(rdata),
      .irq_ctl(ctl), .key_interrupt_request(req_p), .key_flag(flag),
      .key_irq_pending(pend), .port_pin_level(lvl),
      .key_detect_enable(en));

   // four-channel variant, bus passed on only while its test runs
   assign req4 = narrow ? req : '0;
   kei_key_edge_interrupt #(.NUM_CH(4)) uut4 (.ref_clk(ref_clk),
      .resetn(resetn), .key_input_pin(pins[3:0]), .cpu_req(req4),
      .cpu_rdata(), .irq_ctl(ctl), .key_interrupt_request(),
      .key_flag(flag4), .key_irq_pending(), .port_pin_level(),
      .key_detect_enable(en4));

   // 10 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // count one-cycle request pulses
   always @(posedge ref_clk) if (req_p === 1'b1) npulse <= npulse + 1;

   // ****************************************************************
   // bus and compare helpers
   // ****************************************************************
   task automatic tick(int n = 1);
      repeat (n) @(posedge ref_clk);
      #10;
   endtask
   task automatic chk8(logic [7:0] got, logic [7:0] exp, string m);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic chk1(logic got, logic exp, string m);
      chk8({7'h00, got}, {7'h00, exp}, m);
   endtask
   task automatic wr_byte(logic [15:0] a, logic [7:0] v);
      req.addr = a;
      req.wdata = v;
      req.byte_wr = 1'b1;
      tick();
      req.byte_wr = 1'b0;
      tick();
   endtask
   task automatic wr_bit(logic [2:0] b, logic v);
      req.addr = 16'hFF6E;
      req.bit_sel = b;
      req.bit_val = v;
      req.bit_wr = 1'b1;
      tick();
      req.bit_wr = 1'b0;
      tick();
   endtask
   task automatic rd_reg(logic [15:0] a, output logic [7:0] v);
      req.addr = a;
      req.rd = 1'b1;
      tick();
      req.rd = 1'b0;
      v = rdata;
      tick();
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset();
      chk8(en, 8'h00, "enable after reset");
      chk8(lvl, 8'hFF, "pin levels idle");
      wr_byte(16'hFF6E, 8'hA5);
      chk8(en, 8'hA5, "write before reset");
      resetn = 1'b0;
      tick(2);
      resetn = 1'b1;
      tick(3);
      rd_reg(16'hFF6E, d);
      chk8(d, 8'h00, "enable after second reset");
      $display("test reset done");
   endtask
   task automatic t_reg();
      wr_byte(16'hFF6E, 8'h5A);
      rd_reg(16'hFF6E, d);
      chk8(d, 8'h5A, "byte readback");
      wr_byte(16'hFF6F, 8'hFF);
      chk8(en, 8'h5A, "write elsewhere ignored");
      rd_reg(16'hFF6D, d);
      chk8(d, 8'h00, "read elsewhere");
      wr_bit(3'h0, 1'b1);
      wr_bit(3'h6, 1'b0);
      wr_bit(3'h7, 1'b1);
      rd_reg(16'hFF6E, d);
      chk8(d, 8'h9B, "bit writes");
      $display("test register done");
   endtask
   task automatic t_edge();
      logic [7:0] base;
      for (int i = 0; i < 8; i++) begin
         wr_byte(16'hFF6E, 8'h01 << i);
         base = npulse[7:0];
         press = ~(8'h01 << i);
         tick(6);
         chk8(lvl, 8'h01 << i, "port view");
         press = 8'hFF;
         tick(6);
         chk8(npulse[7:0] - base, 8'h01, "one pulse per fall");
         press = 8'h00;
         tick(6);
      end
      $display("test edges done");
   endtask
   task automatic t_live();
      logic [7:0] base;
      ctl.global_ie = 1'b0;
      wr_byte(16'hFF6E, 8'h00);
      press = 8'h08;
      tick(6);
      base = npulse[7:0];
      wr_byte(16'hFF6E, 8'h08);
      tick(4);
      chk8(npulse[7:0] - base, 8'h01, "enable on low pin");
      chk1(flag, 1'b1, "flag set");
      ctl.flag_clr = 1'b1;
      tick();
      ctl.flag_clr = 1'b0;
      chk1(flag, 1'b0, "flag cleared");
      ctl.global_ie = 1'b1;
      tick(2);
      chk1(pend, 1'b0, "nothing pending");
      press = 8'h00;
      tick(6);
      $display("test live enable done");
   endtask
   task automatic t_flag();
      ctl.mask = 1'b1;
      wr_byte(16'hFF6E, 8'h01);
      press = 8'h01;
      tick(3);
      // clear lands on the same edge as the pulse, set must win
      ctl.flag_clr = 1'b1;
      tick();
      ctl.flag_clr = 1'b0;
      chk1(flag, 1'b1, "flag held");
      tick(2);
      chk1(pend, 1'b0, "masked");
      ctl.mask = 1'b0;
      tick(2);
      chk1(pend, 1'b1, "unmasked pending");
      ctl.global_ie = 1'b0;
      tick(2);
      chk1(pend, 1'b0, "globally disabled");
      ctl.flag_clr = 1'b1;
      tick();
      ctl.flag_clr = 1'b0;
      chk1(flag, 1'b0, "flag cleared");
      press = 8'h00;
      tick(6);
      $display("test flag done");
   endtask
   task automatic t_narrow();
      narrow = 1'b1;
      chk8(en4, 8'h00, "four-channel idle");
      wr_byte(16'hFF6E, 8'h0F);
      chk8(en4, 8'h0F, "four-channel enable");
      chk1(flag4, 1'b0, "four-channel quiet");
      press = 8'h08;
      tick(6);
      chk1(flag4, 1'b1, "four-channel key press");
      press = 8'h00;
      tick(6);
      $display("test four channels done");
   endtask

   // ****************************************************************
   // verdict, watchdog and main sequence
   // ****************************************************************
   task automatic finish_test();
      $display("errors %0d checks %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // cut a hang short well past the expected run length
   initial begin
      #100000;
      n_errors++;
      $display("BAD %0t watchdog expired", $time);
      finish_test();
   end

   initial begin
      resetn = 1'b0;
      press = 8'h00;
      req = '0;
      ctl = '0;
      tick(2);
      resetn = 1'b1;
      tick(3);
      t_reset();
      t_reg();
      t_edge();
      t_live();
      t_flag();
      t_narrow();
      finish_test();
   end
endmodule
